// ==== core/dmac_addr_ctr.sv ====
// Address counter of one port: fixed, incrementing or decrementing
`timescale 1ns/100ps
module dmac_addr_ctr
    import dmac_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         load,     // Copy start value
    input  wire logic         step,     // One byte finished
    input  wire logic [1:0]   mode,     // Counting mode
    input  wire logic [W-1:0] startVal, // Buffered start address
    output logic      [W-1:0] count     // Live address
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [W-1:0] cnt;
    } dmacCtr_t;

    dmacCtr_t st_ff;   // Registered state
    dmacCtr_t nxt_st;  // Next state

    // Load wins over a step in the same cycle
    always_comb begin
        nxt_st = st_ff;
        if (load) begin
            nxt_st.cnt = startVal;
        end else if (step) begin
            // R14: per-port mode
            case (mode)
                DMAC_AM_INC: nxt_st.cnt = st_ff.cnt + W'(1);
                DMAC_AM_DEC: nxt_st.cnt = st_ff.cnt - W'(1);
                default:     nxt_st.cnt = st_ff.cnt; // Fixed address
            endcase
        end
    end

    // Clock enable freezes the counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign count = st_ff.cnt;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ctr_step_mode: assert property ( // R14
        (ce && step && !load && mode == DMAC_AM_DEC) |=> count == $past(count) - W'(1))
        else $error("address counter did not decrement");
endmodule : dmac_addr_ctr

// ==== core/dmac_core.sv ====
// Register, counter and pulse core of a single-channel DMA engine
// Operation
// R1: 21 control and 7 status registers
// R2: eight-bit registers, word pairs low then high
// R3: base byte first, then pointed registers
// R4: counters behind start and length registers
// R5: address counters drive bus, all readable
// R6: register writes never disturb running counters
// R7: live length compare stops or restarts
// R8: pulse offset compared with counter low byte
// R9: pulse whenever offset equals low byte
// R10: pulses only while owning the bus
// R11: status reads step through masked set
// R12: status byte readable on its own
// R13: port addresses multiplexed on one bus
// R14: address fixed, incrementing or decrementing
// R15: byte counter starts zero, counts bytes
// R16: end of block moves one extra byte
// R17: two-cycle simultaneous adds second extra byte
// R18: match seen after next byte read
// R19: simultaneous match extra byte unless ready drops; ready loss skips it only in burst mode
// R20: forced ready acts as active ready
// R21: pointed registers taken in ascending order
// R22: load and restart copy start, clear count
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/100ps
module dmac_core
    import dmac_pkg::*;
#(
    parameter int AW = 16 // Address and counter width
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,         // Freezes all state when low
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic      [31:0]   hrdata,
    input  wire logic          rdyIn,      // Peripheral ready pin
    input  wire logic          busGrant,   // bus_grant_line, active high
    input  wire logic          byteDone,   // One byte operation finished
    input  wire logic [7:0]    dataIn,     // Byte read in that operation
    input  wire logic          portSel,    // 0 port A, 1 port B on bus
    output logic               busRequest, // bus_request_line, active high
    output logic               pulseOut,   // Pulse on the interrupt pin
    output logic      [AW-1:0] addrBus     // Multiplexed system address
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        // R1: control storage, status read by index
        logic [DMAC_NUM_CTL-1:0][7:0] ctl; // Control storage by index
        logic [2:0]            grp;        // Group being filled
        logic [DMAC_PTR_W-1:0] ptr;        // Pointer bits left to serve
        logic [2:0]            rdIdx;      // Next status register
        logic                  enabled;    // Block running
        logic                  forceRdy;   // Forced ready
        logic                  bus_request_line;     // Bus request
        logic                  pulse;      // Periodic pulse
        logic                  matchPend;  // Match waiting for next byte
        logic                  extra;      // Extra end-of-block byte taken
        logic                  eob;        // End of block reached
        logic                  matched;    // Stopped on a match
        logic [AW-1:0]         byteCnt;    // Byte counter
        logic [AW-1:0]         addr;       // Address bus register
        logic                  dphValid;   // Data phase owed
        logic                  dphWrite;
        logic                  dphPort;    // Data phase hits the port
        logic [7:0]            rdData;
        logic                  rdyOut;
    } dmacSt_t;

    dmacSt_t st_ff;  // Registered state
    dmacSt_t nxt_st; // Next state

    logic [AW-1:0] cntA;      // Port A address
    logic [AW-1:0] cntB;      // Port B address
    logic          loadNow;   // Counters reload
    logic          step;      // Byte counted while running
    logic          cntInc;    // Byte counter advances
    logic          readyEff;  // Ready after polarity and forcing
    logic          matchHit;  // Current byte matches
    logic          takeAph;   // Address phase accepted
    logic          takePort;
    logic          takeStat;
    logic [7:0]    statByte;
    logic [7:0]    wrByte;
    logic [AW-1:0] blockLen;  // Live block length register
    logic [7:0]    rdMask;

    // ****************************************
    // Helpers
    // ****************************************
    // Lowest set pointer bit
    function automatic logic [1:0] lowBit(input logic [DMAC_PTR_W-1:0] p);
        lowBit = 2'h0;
        for (int i = DMAC_PTR_W - 1; i >= 0; i--) begin
            if (p[i]) begin
                lowBit = 2'(i);
            end
        end
    endfunction : lowBit

    // Next masked status index after cur, wrapping
    function automatic logic [2:0] nextMasked(input logic [2:0] cur,
                                              input logic [7:0] m);
        logic [2:0] k;
        nextMasked = cur;
        k = cur;
        for (int i = 0; i < DMAC_NUM_STAT; i++) begin
            k = (k == 3'(DMAC_NUM_STAT - 1)) ? 3'h0 : k + 3'h1;
            if (m[k] && nextMasked == cur) begin
                nextMasked = k;
            end
        end
    endfunction : nextMasked

    // Pair of control bytes as one word
    function automatic logic [AW-1:0] ctlWord(input dmacSt_t s, input logic [4:0] lo);
        ctlWord = AW'({s.ctl[lo + 5'h1], s.ctl[lo]});
    endfunction : ctlWord

    // ****************************************
    // Port address counters
    // ****************************************
    // R5: counters drive the address bus
    dmac_addr_ctr #(.W(AW)) uCtrA (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .load     (loadNow),
        .step     (step),
        .mode     (st_ff.ctl[DMAC_G_AMOD][DMAC_F_MODE_LO +: 2]),
        .startVal (ctlWord(st_ff, DMAC_I_STA_LO)),
        .count    (cntA)
    );

    dmac_addr_ctr #(.W(AW)) uCtrB (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .load     (loadNow),
        .step     (step),
        .mode     (st_ff.ctl[DMAC_G_BMOD][DMAC_F_MODE_LO +: 2]),
        .startVal (ctlWord(st_ff, DMAC_I_STB_LO)),
        .count    (cntB)
    );

    // ****************************************
    // Decode
    // ****************************************
    // Bus phases and live conditions
    always_comb begin
        blockLen = ctlWord(st_ff, DMAC_I_LEN_LO);
        rdMask   = st_ff.ctl[DMAC_I_RDMASK];
        wrByte   = hwdata[7:0];
        takeAph  = hsel && htrans[1] && hready;
        takePort = takeAph && !hwrite && (haddr[7:0] & DMAC_OFS_MSK) == DMAC_OFS_PORT
                   && haddr[31:8] == 24'h0;
        takeStat = takeAph && !hwrite && haddr == {24'h0, DMAC_OFS_STAT};
        // R20: forced ready looks like active ready
        readyEff = st_ff.forceRdy
                   || (rdyIn == st_ff.ctl[DMAC_G_OPT][DMAC_F_RDYHI]);
        step     = byteDone && st_ff.enabled;
        matchHit = ((dataIn ^ st_ff.ctl[DMAC_I_MATCH]) & ~st_ff.ctl[DMAC_I_MMASK]) == 8'h0;
        statByte = 8'h0;
        statByte[DMAC_S_ENA] = st_ff.enabled;
        statByte[DMAC_S_MT]  = st_ff.matched;
        statByte[DMAC_S_EOB] = st_ff.eob;
        statByte[DMAC_S_RDY] = readyEff;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [4:0] idx;
        logic [1:0] sb;
        logic [2:0] g;
        logic       stop;
        logic       restart;
        logic [7:0] rv;
        idx     = 5'h0;
        sb      = 2'h0;
        g       = 3'h0;
        stop    = 1'b0;
        restart = 1'b0;
        rv      = 8'h0;
        nxt_st  = st_ff;
        loadNow = 1'b0;
        cntInc  = 1'b0;
        nxt_st.rdyOut = 1'b1;
        nxt_st.pulse  = 1'b0;

        // Address phase registered for the data phase
        if (takeAph) begin
            nxt_st.dphValid = hwrite && hsize == 3'h2;
            nxt_st.dphWrite = hwrite;
            nxt_st.dphPort  = haddr == {24'h0, DMAC_OFS_PORT};
        end else begin
            nxt_st.dphValid = 1'b0;
        end

        // R11: masked status sequence, read advances it
        if (takePort) begin
            case (st_ff.rdIdx)
                3'h0:    rv = statByte;
                3'h1:    rv = st_ff.byteCnt[7:0];
                3'h2:    rv = st_ff.byteCnt[15:8];
                3'h3:    rv = cntA[7:0];
                3'h4:    rv = cntA[15:8];
                3'h5:    rv = cntB[7:0];
                3'h6:    rv = cntB[15:8];
                default: rv = 8'h0;
            endcase
            nxt_st.rdIdx = nextMasked(st_ff.rdIdx, rdMask);
        // R12: status byte outside the sequence
        end else if (takeStat) begin
            rv = statByte;
        end
        nxt_st.rdData = rv;

        // R6: writes reach storage only, never counters
        // Control byte arriving through the write port
        if (st_ff.dphValid && st_ff.dphWrite && st_ff.dphPort) begin
            if (st_ff.ptr == '0) begin
                // R3: base byte selects group and pointer bits
                g = wrByte[DMAC_GRP_HI:DMAC_GRP_LO];
                if (g < 3'(DMAC_NUM_GRP)) begin
                    nxt_st.ctl[g] = wrByte;
                    nxt_st.grp    = g;
                    nxt_st.ptr    = wrByte[DMAC_PTR_W-1:0]
                                    & DMAC_PTR_W'((5'h1 << dmacGrpSubs(g)) - 5'h1);
                end
                if (g == DMAC_G_CMD) begin
                    case (wrByte[DMAC_F_CMD_LO +: 3])
                        DMAC_CMD_LOAD:  loadNow = 1'b1;
                        DMAC_CMD_ENA:   nxt_st.enabled = 1'b1;
                        DMAC_CMD_DIS: begin
                            nxt_st.enabled  = 1'b0;
                            nxt_st.forceRdy = 1'b0;
                        end
                        DMAC_CMD_FRDY:  nxt_st.forceRdy = 1'b1;
                        DMAC_CMD_RDSEQ: nxt_st.rdIdx = nextMasked(3'(DMAC_NUM_STAT - 1),
                                                                  rdMask);
                        DMAC_CMD_CLR: begin
                            nxt_st.eob     = 1'b0;
                            nxt_st.matched = 1'b0;
                        end
                        default: ;
                    endcase
                end
            end else begin
                // R21: lowest pointed register first, skip the rest
                sb  = lowBit(st_ff.ptr);
                idx = dmacGrpFirst(st_ff.grp) + 5'(sb);
                // R2: word halves live in neighbouring slots
                nxt_st.ctl[idx] = wrByte;
                nxt_st.ptr[sb]  = 1'b0;
            end
        end

        // R7: live length compare at each finished byte
        if (step) begin
            cntInc = 1'b1;
            if (st_ff.matchPend) begin
                // R18: stop once the byte after the match is read
                stop = 1'b1;
                nxt_st.matched = 1'b1;
            end else if (st_ff.byteCnt == blockLen || st_ff.extra) begin
                if (st_ff.ctl[DMAC_G_OPT][DMAC_F_AUTORS]) begin
                    restart = 1'b1;
                // R17: second extra byte while ready holds
                end else if (!st_ff.extra && readyEff
                             && st_ff.ctl[DMAC_G_MTCH][DMAC_F_SIMUL]
                             && st_ff.ctl[DMAC_G_OPT][DMAC_F_2CYC]) begin
                    nxt_st.extra = 1'b1;
                end else begin
                    // R16: count stays at length, one byte beyond it moved
                    stop   = 1'b1;
                    cntInc = 1'b0;
                    nxt_st.eob = 1'b1;
                end
            end
            if (matchHit && st_ff.ctl[DMAC_G_MTCH][DMAC_F_STOPMT] && !stop) begin
                nxt_st.matchPend = 1'b1;
            end
        end

        // R19: in burst mode, ready loss skips the extra simultaneous byte
        if (st_ff.matchPend && !readyEff && st_ff.enabled
            && st_ff.ctl[DMAC_G_MTCH][DMAC_F_SIMUL]
            && st_ff.ctl[DMAC_G_MTCH][DMAC_F_BURST]) begin
            stop = 1'b1;
            nxt_st.matched = 1'b1;
        end

        if (stop) begin
            nxt_st.enabled   = 1'b0;
            nxt_st.matchPend = 1'b0;
            nxt_st.extra     = 1'b0;
        end

        // R22: reload on command or restart
        loadNow = loadNow || restart;
        if (loadNow) begin
            // R15: fresh block counts from zero
            nxt_st.byteCnt   = '0;
            nxt_st.extra     = 1'b0;
            nxt_st.matchPend = 1'b0;
        end else if (cntInc) begin
            nxt_st.byteCnt = st_ff.byteCnt + AW'(1);
        end

        // R8: offset against counter low byte
        // R9: pulse when low byte reaches the offset
        if (cntInc && !loadNow && nxt_st.byteCnt[7:0] == st_ff.ctl[DMAC_I_PLSOFS]) begin
            // R10: only while the bus is ours
            nxt_st.pulse = st_ff.bus_request_line && busGrant;
        end

        nxt_st.bus_request_line = nxt_st.enabled && readyEff;
        // R13: selected port drives the shared bus
        nxt_st.addr = portSel ? cntB : cntA;
    end

    // ****************************************
    // Registers
    // ****************************************
    // R4: counters change only by load or step, never by writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign hreadyout  = st_ff.rdyOut;
    assign hresp      = 1'b0 & st_ff.rdyOut;
    assign hrdata     = {24'h0, st_ff.rdData};
    assign busRequest = st_ff.bus_request_line;
    assign pulseOut   = st_ff.pulse;
    assign addrBus    = st_ff.addr;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_pulse_master: assert property ($rose(pulseOut) |-> $past(busRequest && busGrant)) // R10
        else $error("pulse without bus ownership");
    a_cnt_load: assert property ((ce && loadNow) |=> st_ff.byteCnt == '0) // R22
        else $error("byte counter not cleared on load");
    a_cnt_step: assert property ( // R15
        (ce && cntInc && !loadNow) |=> st_ff.byteCnt == $past(st_ff.byteCnt) + AW'(1))
        else $error("byte counter did not step");
    a_cnt_hold: assert property ((ce && !loadNow && !byteDone) |=> $stable(st_ff.byteCnt)) // R6
        else $error("byte counter changed without a byte");
    a_eob_stop: assert property ( // R7
        (ce && step && !st_ff.matchPend && st_ff.byteCnt == blockLen
         && !st_ff.ctl[DMAC_G_OPT][DMAC_F_AUTORS] && !st_ff.ctl[DMAC_G_MTCH][DMAC_F_SIMUL])
        |=> !st_ff.enabled && st_ff.eob)
        else $error("end of block did not stop");
    a_addr_mux: assert property ( // R13
        ce |=> addrBus == ($past(portSel) ? $past(cntB) : $past(cntA)))
        else $error("address bus shows wrong port");
    a_bus_request_line_rdy: assert property ($rose(busRequest) |-> $past(readyEff && nxt_st.enabled)) // R20
        else $error("bus requested without ready");
    a_stat_read: assert property ((ce && takeStat) |=> hrdata[7:0] == $past(statByte)) // R12
        else $error("status byte read wrong");
    a_seq_mask: assert property ( // R11
        (ce && takePort && rdMask[6:0] != 7'h0 && !st_ff.dphValid) |=> rdMask[st_ff.rdIdx])
        else $error("read sequence left the mask");
    a_match_late: assert property ( // R18
        (ce && step && matchHit && !st_ff.matchPend && st_ff.ctl[DMAC_G_MTCH][DMAC_F_STOPMT]
         && st_ff.byteCnt != blockLen && !st_ff.extra && !st_ff.dphValid)
        |=> st_ff.matchPend && st_ff.enabled)
        else $error("match stopped before next byte");
endmodule : dmac_core

// ==== dv/dmac_core_bench.sv ====
// Self-checking bench of the DMA register and counter core
`timescale 1ns/100ps
module dmac_core_bench;
    import dmac_pkg::*;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, rdyIn = 0, portSel = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0]  htrans = 0;
    logic        hreadyout, hresp, busRequest, pulseOut, busGrant, byteDone;
    logic [7:0]  dataIn, seed = 8'h19, ofs, q[$];
    logic [15:0] addrBus, sa, sb, n;
    logic [47:0] e;
    int          mismatches = 0, testsRun = 0, pulses = 0, i;
    always #20 clk = ~clk;
    always @(posedge clk) if (pulseOut === 1'b1) pulses <= pulses + 1;
    dmac_core dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rdyIn(rdyIn), .busGrant(busGrant), .byteDone(byteDone), .dataIn(dataIn),
        .portSel(portSel), .busRequest(busRequest), .pulseOut(pulseOut), .addrBus(addrBus));
    dmac_far_side far (.clk(clk), .busRequest(busRequest), .busGrant(busGrant),
        .byteDone(byteDone), .dataIn(dataIn));
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic close_out;
        if (mismatches == 0 && testsRun > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    // Single AHB transfer; hold each phase until hready seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask : bus
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        seed = lfsr(seed);
        n = {10'h0, seed[5:0]} + 16'd4;
        sa = {seed, 8'h30};
        seed = lfsr(seed);
        sb = {8'h90, seed};
        rdyIn <= seed[0];
        ofs = n[7:0] - 8'd2;
        // base bytes then pointed registers, load, force ready, enable
        q = '{8'h0f, sa[7:0], sa[15:8], n[7:0], n[15:8], 8'h44, 8'h87, sb[7:0],
              sb[15:8], ofs, 8'ha0, 8'hc1, 8'h7e, 8'hc2, 8'hc8, 8'hc4};
        foreach (q[i]) bus(1'b1, DMAC_OFS_PORT, q[i]);
        i = 0;
        do begin
            bus(1'b0, DMAC_OFS_STAT, 8'h00);
            i++;
        end while (r[DMAC_S_EOB] !== 1'b1 && i < 500);
        chk("eob", r[DMAC_S_EOB], 1'b1);
        // Model: count ends at N, port A moved N+1 bytes, port B fixed
        e = {sb, sa + n + 16'd1, n};
        bus(1'b1, DMAC_OFS_PORT, 8'hca);
        for (i = 0; i < 6; i++) begin
            bus(1'b0, DMAC_OFS_PORT, 8'h00);
            chk("readback", r, {24'h0, e[8*i+:8]});
        end
        chk("request", busRequest, 1'b0);
        chk("addrBus", addrBus, sb);
        chk("pulses", pulses, 1);
        chk("hresp", hresp, 1'b0);
        // Port A on the bus: stopped N+1 bytes past its start
        portSel <= 1'b0;
        repeat (2) @(posedge clk);
        chk("addrA", addrBus, sa + n + 16'd1);
        // Stop on match, every bit masked: first byte matches
        q = '{8'h67, 8'h00, 8'hff, 8'hcc, 8'hc2, 8'hc4};
        foreach (q[i]) bus(1'b1, DMAC_OFS_PORT, q[i]);
        i = 0;
        do begin
            bus(1'b0, DMAC_OFS_STAT, 8'h00);
            i++;
        end while (r[DMAC_S_MT] !== 1'b1 && i < 500);
        // Stopped on match, block end cleared, ready still forced
        chk("matchStat", r[3:0], 4'ha);
        // Matched byte plus the byte read after it
        chk("matchAddr", addrBus, sa + 16'd2);
        close_out;
    end
endmodule : dmac_core_bench

// ==== dv/dmac_far_side.sv ====
// Far-side model: processor bus grant and byte engine
`timescale 1ns/100ps
module dmac_far_side (
    input  wire logic       clk,
    input  wire logic       busRequest,
    output logic            busGrant,
    output logic            byteDone,
    output logic [7:0]      dataIn
);
    initial begin
        busGrant = 1'b0;
        byteDone = 1'b0;
        dataIn   = 8'h00;
    end
    // ****************************************
    // Grant one cycle late, a byte every other cycle
    // ****************************************
    always @(posedge clk) begin
        busGrant <= busRequest;
        byteDone <= busGrant && busRequest && !byteDone;
        // Idle data toggles so no stale byte looks valid
        dataIn   <= ~dataIn;
    end
endmodule : dmac_far_side

// ==== include/dmac_pkg.sv ====
// Shared constants and types of the DMA register and counter core
package dmac_pkg;
    // ****************************************
    // Bus map
    // ****************************************
    // Byte address of control write port and masked status reads
    localparam logic [7:0] DMAC_OFS_PORT = 8'h00;
    // Byte address of the lone status byte
    localparam logic [7:0] DMAC_OFS_STAT = 8'h04;
    localparam logic [7:0] DMAC_OFS_MSK  = 8'hfc;
    localparam logic [1:0] DMAC_HTRANS_BUSY = 2'h1;

    // ****************************************
    // Control register groups
    // ****************************************
    localparam int DMAC_NUM_GRP  = 7;
    localparam int DMAC_NUM_CTL  = 21;
    localparam int DMAC_NUM_STAT = 7;
    // Base byte layout: group id on top, pointer bits at the bottom
    localparam int DMAC_GRP_HI = 7;
    localparam int DMAC_GRP_LO = 5;
    localparam int DMAC_PTR_W  = 4;
    // Group ids
    localparam logic [2:0] DMAC_G_LEN  = 3'h0; // port_a_and_length_group
    localparam logic [2:0] DMAC_G_AMOD = 3'h1;
    localparam logic [2:0] DMAC_G_BMOD = 3'h2;
    localparam logic [2:0] DMAC_G_MTCH = 3'h3;
    localparam logic [2:0] DMAC_G_PLS  = 3'h4; // port_b_and_pulse_group
    localparam logic [2:0] DMAC_G_OPT  = 3'h5;
    localparam logic [2:0] DMAC_G_CMD  = 3'h6; // command_and_read_mask_group
    // Storage index of the named sub-registers (bases sit at index = group id)
    localparam logic [4:0] DMAC_I_STA_LO = 5'h07;
    localparam logic [4:0] DMAC_I_STA_HI = 5'h08;
    localparam logic [4:0] DMAC_I_LEN_LO = 5'h09;
    localparam logic [4:0] DMAC_I_LEN_HI = 5'h0a;
    localparam logic [4:0] DMAC_I_MATCH  = 5'h0d;
    localparam logic [4:0] DMAC_I_MMASK  = 5'h0e;
    localparam logic [4:0] DMAC_I_STB_LO = 5'h0f;
    localparam logic [4:0] DMAC_I_STB_HI = 5'h10;
    localparam logic [4:0] DMAC_I_PLSOFS = 5'h11;
    localparam logic [4:0] DMAC_I_RDMASK = 5'h14;

    // ****************************************
    // Control fields inside base bytes
    // ****************************************
    localparam int DMAC_F_MODE_LO = 1; // Address mode in port mode groups
    localparam int DMAC_F_STOPMT  = 2; // Stop on byte match
    localparam int DMAC_F_SIMUL   = 3; // Simultaneous transfer/search
    localparam int DMAC_F_AUTORS  = 2; // Auto restart at end of block
    localparam int DMAC_F_RDYHI   = 3; // Ready input active high
    localparam int DMAC_F_2CYC    = 4; // Two-cycle variable timing
    localparam int DMAC_F_CMD_LO  = 1; // Command code in command base
    localparam int DMAC_F_BURST   = 4; // Burst or continuous mode

    // Commands
    localparam logic [2:0] DMAC_CMD_LOAD  = 3'h1;
    localparam logic [2:0] DMAC_CMD_ENA   = 3'h2;
    localparam logic [2:0] DMAC_CMD_DIS   = 3'h3;
    localparam logic [2:0] DMAC_CMD_FRDY  = 3'h4;
    localparam logic [2:0] DMAC_CMD_RDSEQ = 3'h5;
    localparam logic [2:0] DMAC_CMD_CLR   = 3'h6;

    // Address counting modes
    localparam logic [1:0] DMAC_AM_INC = 2'h0;
    localparam logic [1:0] DMAC_AM_DEC = 2'h1;

    // Status byte bits
    localparam int DMAC_S_ENA = 0;
    localparam int DMAC_S_MT  = 1;
    localparam int DMAC_S_EOB = 2;
    localparam int DMAC_S_RDY = 3;

    // Sub-register count of a group
    function automatic logic [2:0] dmacGrpSubs(input logic [2:0] g);
        case (g)
            DMAC_G_LEN:  dmacGrpSubs = 3'h4;
            DMAC_G_PLS:  dmacGrpSubs = 3'h3;
            DMAC_G_MTCH: dmacGrpSubs = 3'h2;
            DMAC_G_OPT:  dmacGrpSubs = 3'h2;
            DMAC_G_AMOD, DMAC_G_BMOD, DMAC_G_CMD: dmacGrpSubs = 3'h1;
            default:     dmacGrpSubs = 3'h0;
        endcase
    endfunction : dmacGrpSubs

    // Storage index of the first sub-register of a group
    function automatic logic [4:0] dmacGrpFirst(input logic [2:0] g);
        case (g)
            DMAC_G_LEN:  dmacGrpFirst = DMAC_I_STA_LO;
            DMAC_G_AMOD: dmacGrpFirst = 5'h0b;
            DMAC_G_BMOD: dmacGrpFirst = 5'h0c;
            DMAC_G_MTCH: dmacGrpFirst = DMAC_I_MATCH;
            DMAC_G_PLS:  dmacGrpFirst = DMAC_I_STB_LO;
            DMAC_G_OPT:  dmacGrpFirst = 5'h12;
            default:     dmacGrpFirst = DMAC_I_RDMASK;
        endcase
    endfunction : dmacGrpFirst
endpackage : dmac_pkg
